// file: xbus_decode.sv
// xbus_decode: classifies an access address as on-chip or off-chip
// assumes the address is stable from the same clock domain
`timescale 1ns/1ps
module xbus_decode
    import xbus_pkg::*;
#(
    parameter int unsigned AW = ADDR_W
) (
    // address in
    input  wire logic [AW-1:0] addr,
    // classification out
    output logic               onchip
);
    // on-chip when the address lies inside the internal window
    always_comb begin
        onchip = (addr >= AW'(ONCHIP_BASE)) && (addr <= AW'(ONCHIP_TOP));
    end
endmodule

// file: xbus_mem_model.sv
// xbus_mem_model: external memory answering the pin stage's bus cycles
// assumes its pins come straight from the pin stage on the same clock
`timescale 1ns/1ps
module xbus_mem_model
    import xbus_pkg::*;
(
    // clock
    input  wire logic              clock,
    // pins from the device
    input  wire logic [ADDR_W-1:0] addr_pin,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe_n,
    input  wire logic              rw_pin,
    input  wire logic              address_strobe_n,
    input  wire logic              wr_strobe_n,
    // data lines back to the device
    output logic [DATA_W-1:0]      data_in
);
    logic [DATA_W-1:0] mem_q [16];
    logic [DATA_W-1:0] last_q = 16'h0F0F;
    ////////////////////////////////////////////////////////////////////////
    // drive only in a read cycle; otherwise toggle so a stale sample shows
    always_comb begin
        data_in = (address_strobe_n == STB_ACTIVE && rw_pin == RW_READ) ? mem_q[addr_pin[3:0]] : ~last_q;
    end
    // store on the write strobe; never reaches device registers
    always @(posedge clock) begin
        last_q <= data_in;
        if (wr_strobe_n == STB_ACTIVE && data_oe_n == OE_DRIVE) begin
            mem_q[addr_pin[3:0]] <= data_out;
        end
    end
endmodule

// file: xbus_pins.sv
// xbus_pins: external bus pin stage driven by the processor core accesses
// assumes the core holds req and its fields until done; pins resolved outside
`timescale 1ns/1ps
module xbus_pins
    import xbus_pkg::*;
#(
    parameter int unsigned AW = ADDR_W,
    parameter int unsigned DW = DATA_W
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // core access request
    input  wire logic          req,
    input  wire logic          wr,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic               done,
    output logic               onchip_sel,
    output logic [DW-1:0]      rdata,
    // external pins
    output logic [AW-1:0]      addr_pin,
    output logic [DW-1:0]      data_out,
    output logic               data_oe_n,
    input  wire logic [DW-1:0] data_in,
    output logic               rw_pin,
    output logic               address_strobe_n,
    output logic               data_strobe_n,
    output logic               rd_strobe_n,
    output logic               wr_strobe_n
);
    ////////////////////////////////////////////////////////////////////////
    bus_state_t        state_q, state_d;
    logic [1:0]        cnt_q, cnt_d;
    logic [AW-1:0]     addr_q, addr_d;
    logic [DW-1:0]     wdat_q, wdat_d;
    logic              wr_q, wr_d;
    logic [DW-1:0]     rdat_q, rdat_d;
    logic [DW-1:0]     sync1_q, sync2_q;
    logic              dec_onchip;

    xbus_decode #(.AW(AW)) u_dec (
        .addr   (addr),
        .onchip (dec_onchip)
    );

    // data pins pass two flops since they come from outside the clock
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= data_in;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access sequencer; no external port exists into on-chip registers
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        wr_d    = wr_q;
        rdat_d  = rdat_q;
        unique case (state_q)
            ST_IDLE: begin
                if (req) begin
                    addr_d  = addr;
                    wdat_d  = wdata;
                    wr_d    = wr;
                    cnt_d   = CNT_RST;
                    state_d = dec_onchip ? ST_INT : ST_EXT;
                end
            end
            ST_INT: begin
                state_d = ST_IDLE; // internal access takes one cycle
            end
            ST_EXT: begin
                cnt_d = cnt_q + 2'h1;
                if (cnt_q == EXT_CYCLES - 2'h1) begin
                    // sample late so the synchroniser has settled
                    if (!wr_q)
                        rdat_d = sync2_q;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_RST;
            addr_q  <= '0;
            wdat_q  <= '0;
            wr_q    <= 1'b0;
            rdat_q  <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            wr_q    <= wr_d;
            rdat_q  <= rdat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin levels; registered state only, so pins never glitch
    logic ext_act;
    logic busy;
    logic strobe_win;
    always_comb begin
        ext_act    = (state_q == ST_EXT);
        busy       = (state_q != ST_IDLE);
        strobe_win = ext_act && (cnt_q != CNT_RST);
        addr_pin   = addr_q;
        data_out   = wdat_q;
        data_oe_n  = (ext_act && wr_q) ? OE_DRIVE : OE_FLOAT;
        rw_pin     = (busy && wr_q) ? RW_WRITE : RW_READ;
        address_strobe_n = ext_act ? STB_ACTIVE : STB_IDLE;
        data_strobe_n    = strobe_win ? STB_ACTIVE : STB_IDLE;
        rd_strobe_n      = (strobe_win && !wr_q) ? STB_ACTIVE : STB_IDLE;
        wr_strobe_n      = (strobe_win && wr_q) ? STB_ACTIVE : STB_IDLE;
        done       = (state_q == ST_INT) ||
                     (ext_act && cnt_q == EXT_CYCLES - 2'h1);
        onchip_sel = (state_q == ST_INT);
        rdata      = rdat_q;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_int_float;
        @(posedge clock) disable iff (rst)
        (state_q == ST_INT) |-> data_oe_n == OE_FLOAT;
    endproperty
    a_int_float: assert property (p_int_float) else $error("data driven on-chip");

    property p_int_strobes;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE && dec_onchip) |=> (address_strobe_n && data_strobe_n
            && rd_strobe_n && wr_strobe_n);
    endproperty
    a_int_strobes: assert property (p_int_strobes) else $error("strobe active on-chip");

    property p_addr_out;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE) |=> addr_pin == $past(addr);
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address not on pins");

    property p_rw_dir;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE) |=> rw_pin == !$past(wr);
    endproperty
    a_rw_dir: assert property (p_rw_dir) else $error("direction line wrong");

    property p_ext_cycle;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE && !dec_onchip) |=> !address_strobe_n [*3] ##0 done;
    endproperty
    a_ext_cycle: assert property (p_ext_cycle) else $error("external cycle malformed");

    // write data must stand on the pins in the first cycle the write strobe is low
    property p_ext_wdrive;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE && !dec_onchip && wr) |=> ##1 (!data_oe_n && !wr_strobe_n
            && data_out == $past(wdata, 2));
    endproperty
    a_ext_wdrive: assert property (p_ext_wdrive) else $error("write data not driven");

    // a read cycle opens with the address alone, then two strobed cycles
    property p_ext_rd_strobe;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE && !dec_onchip && !wr) |=> (rd_strobe_n && wr_strobe_n)
            ##1 (!rd_strobe_n && !data_strobe_n && wr_strobe_n) [*2];
    endproperty
    a_ext_rd_strobe: assert property (p_ext_rd_strobe) else $error("read strobes malformed");

    // an on-chip access ends in one cycle and never turns into a bus cycle
    property p_int_one_cycle;
        @(posedge clock) disable iff (rst)
        (req && state_q == ST_IDLE && dec_onchip) |=> (done && onchip_sel && address_strobe_n)
            ##1 !onchip_sel;
    endproperty
    a_int_one_cycle: assert property (p_int_one_cycle) else $error("on-chip access leaked");

    // between accesses nothing may look like a bus cycle to outside parts
    property p_idle_quiet;
        @(posedge clock) disable iff (rst)
        (state_q == ST_IDLE) |-> (address_strobe_n && data_strobe_n && rd_strobe_n && wr_strobe_n
            && data_oe_n == OE_FLOAT && rw_pin == RW_READ);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pins active while idle");

    property p_no_ext_onchip;
        @(posedge clock) disable iff (rst)
        onchip_sel |-> address_strobe_n && data_oe_n;
    endproperty
    a_no_ext_onchip: assert property (p_no_ext_onchip) else $error("on-chip exposed");

    property p_rd_float;
        @(posedge clock) disable iff (rst)
        (ext_act && !wr_q) |-> data_oe_n == OE_FLOAT;
    endproperty
    a_rd_float: assert property (p_rd_float) else $error("data driven on read");

    c_int_rd: cover property (@(posedge clock) disable iff (rst) onchip_sel && rw_pin);
    c_int_wr: cover property (@(posedge clock) disable iff (rst) onchip_sel && !rw_pin);
    c_ext_wr: cover property (@(posedge clock) disable iff (rst) !wr_strobe_n);
    c_ext_rd: cover property (@(posedge clock) disable iff (rst) !rd_strobe_n);
    // an off-chip cycle that runs to its end
    c_ext_done: cover property (@(posedge clock) disable iff (rst) done && !onchip_sel);
endmodule

// file: xbus_pins_test.sv
// xbus_pins_test: self-checking bench for the external bus pin stage
// assumes an external memory model on the pins and an 8 ns clock
`timescale 1ns/1ps
module xbus_pins_test
    import xbus_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [23:0] addr = 24'h0;
    logic [15:0] wdata = 16'h0;
    logic done, onchip_sel, data_oe_n, rw_pin, address_strobe_n, data_strobe_n, rd_strobe_n, wr_strobe_n;
    logic [15:0] rdata, data_out, data_in;
    logic [23:0] addr_pin;
    int fails = 0;
    int compares = 0;
    ////////////////////////////////////////////////////////////////////////
    always #4 clock = ~clock;
    xbus_pins dut (.clock(clock), .rst(rst), .req(req), .wr(wr), .addr(addr), .wdata(wdata), .done(done),
        .onchip_sel(onchip_sel), .rdata(rdata), .addr_pin(addr_pin), .data_out(data_out), .data_oe_n(data_oe_n),
        .data_in(data_in), .rw_pin(rw_pin), .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
        .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));
    xbus_mem_model mem (.clock(clock), .addr_pin(addr_pin), .data_out(data_out), .data_oe_n(data_oe_n),
        .rw_pin(rw_pin), .address_strobe_n(address_strobe_n), .wr_strobe_n(wr_strobe_n), .data_in(data_in));
    ////////////////////////////////////////////////////////////////////////
    // control pins packed: rw, four strobes, enable, done, select
    wire [7:0] ctl = {rw_pin, address_strobe_n, data_strobe_n, rd_strobe_n, wr_strobe_n, data_oe_n, done, onchip_sel};
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one access, judged cycle by cycle; on-chip ends in one cycle, off-chip in three
    task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [15:0] rexp);
        int k;
        logic on;
        logic [7:0] e;
        on = (a >= ONCHIP_BASE && a <= ONCHIP_TOP);
        @(posedge clock);
        #1 {req, wr, addr, wdata} = {1'b1, w, a, d};
        for (k = 1; k <= (on ? 1 : 3); k++) begin
            @(posedge clock);
            #1 check(addr_pin, a);
            e = on ? {~w, 4'hF, OE_FLOAT, 2'b11} : {~w, STB_ACTIVE, k > 1 ? STB_ACTIVE : STB_IDLE,
                (k > 1 && !w) ? STB_ACTIVE : STB_IDLE, (k > 1 && w) ? STB_ACTIVE : STB_IDLE,
                w ? OE_DRIVE : OE_FLOAT, k == 3, 1'b0};
            check({16'h0, ctl}, {16'h0, e});
            if (w && !on) check({8'h0, data_out}, {8'h0, d});
        end
        req = 1'b0;
        @(posedge clock);
        #1 check({16'h0, ctl}, {16'h0, RW_READ, 4'hF, OE_FLOAT, 2'b00});
        if (!w && !on) check({8'h0, rdata}, {8'h0, rexp});
    endtask
    task automatic complete_run();
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset, window edges on-chip, neighbours off-chip
    initial begin
        repeat (12) @(posedge clock);
        #1 check({16'h0, ctl}, {16'h0, RW_READ, 4'hF, OE_FLOAT, 2'b00});
        rst = 1'b0;
        access(1'b1, ONCHIP_BASE, 16'hBEEF, 16'h0);
        access(1'b0, ONCHIP_TOP, 16'h0, 16'h0);
        access(1'b1, ONCHIP_BASE - 24'h1, 16'hA55A, 16'h0);
        access(1'b1, ONCHIP_TOP + 24'h1, 16'h1234, 16'h0);
        access(1'b0, ONCHIP_BASE - 24'h1, 16'h0, 16'hA55A);
        access(1'b0, ONCHIP_TOP + 24'h1, 16'h0, 16'h1234);
        access(1'b0, ONCHIP_BASE, 16'h0, 16'h0);
        complete_run();
    end
    // watchdog well beyond the 41 cycles the sequence needs
    initial begin
        repeat (2000) @(posedge clock);
        fails++;
        complete_run();
    end
endmodule

// file: xbus_pkg.sv
// xbus_pkg: constants shared by the external bus pin stage
// assumes a single 125 MHz clock domain and synchronous active-high reset
package xbus_pkg;
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned DATA_W      = 16;
    localparam logic        RW_READ     = 1'b1;
    localparam logic        RW_WRITE    = 1'b0;
    localparam logic        STB_IDLE    = 1'b1;
    localparam logic        STB_ACTIVE  = 1'b0;
    localparam logic        OE_DRIVE    = 1'b0;
    localparam logic        OE_FLOAT    = 1'b1;
    // cycles of an external bus cycle: address, strobe, finish
    localparam logic [1:0]  EXT_CYCLES  = 2'h3;
    localparam logic [1:0]  CNT_RST     = 2'h0;
    // on-chip window, the rest is off-chip
    localparam logic [23:0] ONCHIP_BASE = 24'h00F680;
    localparam logic [23:0] ONCHIP_TOP  = 24'h00FFFF;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_INT   = 2'b01,
        ST_EXT   = 2'b10
    } bus_state_t;
endpackage
